// file: shared/pdmc_pkg.sv
// Package with constants and types for the power-down mode controller.
package pdmc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] STANDBY_CONTROL_ADDR = 16'hFF1A;
  localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h7F;
  localparam int STANDBY_SELECT_POS = 7;
  localparam logic [6:0] RESERVED_ONES = 7'h7F;
  localparam logic [15:0] MODE_STATUS_ADDR = 16'hFF1B;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEFAULT_SETTLE_NS = 1000;
  localparam int DEFAULT_SETTLE_CYCLES = (DEFAULT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_DIV_BITS = 16;

  // ==========================================================================
  // Modes
  typedef enum logic [5:0] {
    PDMC_RUN = 6'b00_0001,
    PDMC_SLEEP = 6'b00_0010,
    PDMC_SOFT_STANDBY_PIN_N = 6'b00_0100,
    PDMC_NMI_SETTLE = 6'b00_1000,
    PDMC_HARD_STANDBY_PIN_N = 6'b01_0000,
    PDMC_RESET = 6'b10_0000
  } pdmc_mode_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pdmc_bus_s;

  typedef struct packed {
    logic cpuHalt;
    logic cpuRegsLost;
    logic clkGateAll;
    logic clkWdtOnly;
    logic periphReset;
    logic portsHold;
    logic portsHighZ;
    logic chipReset;
  } pdmc_ctrl_s;

endpackage

// file: src/pdmc_edge_sync.sv
// Two-stage synchroniser with a low-level detector for a pin.
`timescale 1ns/100ps
module pdmc_edge_sync
  import pdmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pinIn,
  output logic pinLevel,
  output logic pinLow
);
  logic stage1Reg;
  logic stage2Reg;

  // ==========================================================================
  // Synchroniser
  // Pins reset to high so that a pulled-up pin reads as inactive.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stage1Reg <= 1'b1;
      stage2Reg <= 1'b1;
    end
    else
    begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign pinLevel = stage2Reg;
  assign pinLow = ~stage2Reg;
endmodule

// file: src/pdmc_settle_timer.sv
// Oscillator settling counter on core_clk that advances only while run is high, like the watchdog.
`timescale 1ns/100ps
module pdmc_settle_timer
  import pdmc_pkg::*;
#(
  parameter int CNT_W = 20
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic run,
  input wire logic [CNT_W-1:0] limit,
  output logic overflow
);
  logic [CNT_W-1:0] countReg;

  // ==========================================================================
  // Counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || start)
    begin
      countReg <= '0;
      overflow <= 1'b0;
    end
    else if (run && !overflow)
    begin
      countReg <= countReg + 1'b1;
      overflow <= (countReg + 1'b1) >= limit;
    end
  end
endmodule

// file: src/power_down_mode_control.sv
// Power-down mode controller: sleep, software standby and hardware standby.
// How it works
// RULE_01: Sleep instruction with select bit clear enters sleep; CPU halts, registers kept.
// RULE_02: Sleep instruction with select bit set enters software standby instead.
// RULE_03: In sleep the clock and peripherals run; RAM and ports are held.
// RULE_04: An accepted interrupt ends sleep and starts handling or a transfer.
// RULE_05: Disabled interrupts or those at or below the mask level do not wake.
// RULE_06: Reset pin low during sleep moves the chip into reset.
// RULE_07: Standby pin low during sleep moves directly to hardware standby.
// RULE_08: Software standby halts clock, CPU, peripherals; resets peripherals; keeps state.
// RULE_09: Standby pin low gives hardware standby: clock halts, registers lost, ports float.
// RULE_10: Standby control register is 8 bits at FF1A, resetting to 7F.
// RULE_11: Standby select bit is bit 7, read/write, resets to zero.
// RULE_12: Setting the select bit is ignored while the watchdog is enabled.
// RULE_13: Select bit clears on NMI or reset exit and on hardware standby.
// RULE_14: Bits 6 to 0 are reserved, read-only, always read as one.
// RULE_15: NMI exit clocks only the watchdog until its settling overflow.
// RULE_16: Reset exit clocks the chip at once; sequence starts when reset rises.
// RULE_17: Hardware standby exit needs standby pin high, then reset rising.
// RULE_18: Writes to reserved bits have no effect.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module power_down_mode_control
  import pdmc_pkg::*;
#(
  parameter int SETTLE_W = 20
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdata,
  input wire logic sleepExec,
  input wire logic irqPending,
  input wire logic irqEnabled,
  input wire logic [2:0] irqLevel,
  input wire logic [2:0] statusMaskLevel,
  input wire logic irqIsTransfer,
  input wire logic nmiEvent,
  input wire logic watchdogTimerEnable,
  input wire logic [SETTLE_W-1:0] watchdogSettleCycles,
  input wire logic reset_pin_n,
  input wire logic standby_pin_n,
  output logic cpuHalt,
  output logic cpuRegsLost,
  output logic clkGateAll,
  output logic clkWdtOnly,
  output logic periphReset,
  output logic portsHold,
  output logic portsHighZ,
  output logic chipReset,
  output logic wakeIrq,
  output logic wakeTransfer,
  output logic wakeNmi,
  output logic [5:0] modeOut
);
  pdmc_mode_e modeReg;
  pdmc_mode_e modeNext;
  pdmc_bus_s bus;
  pdmc_ctrl_s ctrlNext;
  logic standbySelectReg;
  logic resetLow;
  logic standbyLow;
  logic settleStart;
  logic settleDone;
  logic irqAccept;
  logic leaveSoftByExit;

  assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

  // ==========================================================================
  // Pin synchronisers
  pdmc_edge_sync u_reset_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(reset_pin_n),
    .pinLevel(),
    .pinLow(resetLow)
  );

  pdmc_edge_sync u_standby_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(standby_pin_n),
    .pinLevel(),
    .pinLow(standbyLow)
  );

  // ==========================================================================
  // Watchdog settling count for NMI recovery
  // The count advances only in the settle mode, where only the watchdog is clocked.
  assign settleStart = (modeReg == PDMC_SOFT_STANDBY_PIN_N) && nmiEvent;
  pdmc_settle_timer #(
    .CNT_W(SETTLE_W)
  ) u_settle (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(settleStart),
    .run(modeReg == PDMC_NMI_SETTLE), // [RULE_15]
    .limit(watchdogSettleCycles),
    .overflow(settleDone)
  );

  // ==========================================================================
  // Interrupt acceptance
  // Priority must be strictly above the mask level to wake the core.
  assign irqAccept = irqPending && irqEnabled && (irqLevel > statusMaskLevel); // [RULE_05]

  // ==========================================================================
  // Mode sequencing
  // Hardware standby wins over every other source, reset wins next.
  always_comb
  begin
    modeNext = modeReg;
    case (modeReg)
      PDMC_RUN:
      begin
        if (standbyLow)
          modeNext = PDMC_HARD_STANDBY_PIN_N;
        else if (resetLow)
          modeNext = PDMC_RESET;
        else if (sleepExec && standbySelectReg)
          modeNext = PDMC_SOFT_STANDBY_PIN_N; // [RULE_02]
        else if (sleepExec)
          modeNext = PDMC_SLEEP; // [RULE_01]
      end
      PDMC_SLEEP:
      begin
        if (standbyLow)
          modeNext = PDMC_HARD_STANDBY_PIN_N; // [RULE_07]
        else if (resetLow)
          modeNext = PDMC_RESET; // [RULE_06]
        else if (irqAccept)
          modeNext = PDMC_RUN; // [RULE_04]
      end
      PDMC_SOFT_STANDBY_PIN_N:
      begin
        if (standbyLow)
          modeNext = PDMC_HARD_STANDBY_PIN_N;
        else if (resetLow)
          modeNext = PDMC_RESET; // [RULE_16]
        else if (nmiEvent)
          modeNext = PDMC_NMI_SETTLE; // [RULE_15]
      end
      PDMC_NMI_SETTLE:
      begin
        if (standbyLow)
          modeNext = PDMC_HARD_STANDBY_PIN_N;
        else if (resetLow)
          modeNext = PDMC_RESET;
        else if (settleDone)
          modeNext = PDMC_RUN; // [RULE_15]
      end
      PDMC_HARD_STANDBY_PIN_N:
      begin
        // Leaving needs the standby pin high; the reset pin then holds the chip.
        if (!standbyLow)
          modeNext = PDMC_RESET; // [RULE_17]
      end
      PDMC_RESET:
      begin
        if (standbyLow)
          modeNext = PDMC_HARD_STANDBY_PIN_N;
        else if (!resetLow)
          modeNext = PDMC_RUN; // [RULE_16] [RULE_17]
      end
      default:
        modeNext = PDMC_RESET;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      modeReg <= PDMC_RESET;
    else
      modeReg <= modeNext;
  end

  // ==========================================================================
  // Standby control register
  assign leaveSoftByExit = (modeReg == PDMC_SOFT_STANDBY_PIN_N || modeReg == PDMC_NMI_SETTLE)
    && (modeNext == PDMC_RUN || modeNext == PDMC_RESET);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      standbySelectReg <= STANDBY_CONTROL_RESET[STANDBY_SELECT_POS]; // [RULE_10] [RULE_11]
    else if (modeNext == PDMC_HARD_STANDBY_PIN_N || leaveSoftByExit)
      standbySelectReg <= 1'b0; // [RULE_13]
    else if (bus.wr && bus.addr == STANDBY_CONTROL_ADDR)
    begin
      // A write of one is dropped while the watchdog runs; a write of zero always lands.
      if (!(bus.wdata[STANDBY_SELECT_POS] && watchdogTimerEnable)) // [RULE_12]
        standbySelectReg <= bus.wdata[STANDBY_SELECT_POS]; // [RULE_11] [RULE_18]
    end
  end

  // Unmapped addresses read as zero; the mode status register shows the state.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      busRdata <= 8'h00;
    else if (bus.rd && bus.addr == STANDBY_CONTROL_ADDR)
      busRdata <= {standbySelectReg, RESERVED_ONES}; // [RULE_14]
    else if (bus.rd && bus.addr == MODE_STATUS_ADDR)
      busRdata <= {2'b00, modeReg};
    else
      busRdata <= 8'h00;
  end

  // ==========================================================================
  // Control outputs
  always_comb
  begin
    ctrlNext = '0;
    case (modeNext)
      PDMC_RUN:
        ctrlNext = '0;
      PDMC_SLEEP:
      begin
        ctrlNext.cpuHalt = 1'b1; // [RULE_01]
        ctrlNext.portsHold = 1'b1; // [RULE_03]
      end
      PDMC_SOFT_STANDBY_PIN_N:
      begin
        ctrlNext.cpuHalt = 1'b1;
        ctrlNext.clkGateAll = 1'b1; // [RULE_08]
        ctrlNext.periphReset = 1'b1; // [RULE_08]
        ctrlNext.portsHold = 1'b1;
      end
      PDMC_NMI_SETTLE:
      begin
        ctrlNext.cpuHalt = 1'b1;
        ctrlNext.clkGateAll = 1'b1;
        ctrlNext.clkWdtOnly = 1'b1; // [RULE_15]
        ctrlNext.periphReset = 1'b1;
        ctrlNext.portsHold = 1'b1;
      end
      PDMC_HARD_STANDBY_PIN_N:
      begin
        ctrlNext.cpuHalt = 1'b1;
        ctrlNext.cpuRegsLost = 1'b1; // [RULE_09]
        ctrlNext.clkGateAll = 1'b1; // [RULE_09]
        ctrlNext.periphReset = 1'b1;
        ctrlNext.portsHighZ = 1'b1; // [RULE_09]
      end
      PDMC_RESET:
      begin
        // The clock runs to the whole chip while the reset pin is held.
        ctrlNext.cpuHalt = 1'b1;
        ctrlNext.chipReset = 1'b1; // [RULE_16]
      end
      default:
        ctrlNext.chipReset = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      {cpuHalt, cpuRegsLost, clkGateAll, clkWdtOnly} <= 4'b1000;
      {periphReset, portsHold, portsHighZ, chipReset} <= 4'b0001;
      modeOut <= PDMC_RESET;
    end
    else
    begin
      {cpuHalt, cpuRegsLost, clkGateAll, clkWdtOnly} <= ctrlNext[7:4];
      {periphReset, portsHold, portsHighZ, chipReset} <= ctrlNext[3:0];
      modeOut <= modeNext;
    end
  end

  // Wake pulses tell the core which handler to start.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wakeIrq <= 1'b0;
      wakeTransfer <= 1'b0;
      wakeNmi <= 1'b0;
    end
    else
    begin
      wakeIrq <= (modeReg == PDMC_SLEEP) && (modeNext == PDMC_RUN) && !irqIsTransfer; // [RULE_04]
      wakeTransfer <= (modeReg == PDMC_SLEEP) && (modeNext == PDMC_RUN) && irqIsTransfer;
      wakeNmi <= (modeReg == PDMC_NMI_SETTLE) && (modeNext == PDMC_RUN); // [RULE_15]
    end
  end
endmodule

// file: bench/pdmc_far_side.sv
// Board pins model: reset held low through oscillator settling.
`timescale 1ns/100ps
module pdmc_far_side
(
  input wire logic core_clk,
  input wire logic stbyReq,
  input wire logic rstReq,
  output logic reset_pin_n,
  output logic standby_pin_n
);
  // Hold length stands in for the oscillator settling time.
  logic [3:0] holdCnt = 4'h0;
  initial reset_pin_n = 1'b0;
  initial standby_pin_n = 1'b1;
  always @(posedge core_clk)
  begin
    standby_pin_n <= !stbyReq;
    holdCnt <= stbyReq ? 4'hF : holdCnt - 4'(holdCnt != 4'h0);
    reset_pin_n <= !(rstReq || stbyReq || holdCnt != 4'h0);
  end
endmodule

// file: bench/pdmc_assertions.sv
// Checker of mode outputs and register reads for the power-down controller.
`timescale 1ns/100ps
module pdmc_assertions
  import pdmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] busAddr,
  input wire logic busRd,
  input wire logic [7:0] busRdata,
  input wire logic sleepExec,
  input wire logic irqPending,
  input wire logic irqEnabled,
  input wire logic [2:0] irqLevel,
  input wire logic [2:0] statusMaskLevel,
  input wire logic nmiEvent,
  input wire logic reset_pin_n,
  input wire logic standby_pin_n,
  input wire logic cpuHalt,
  input wire logic cpuRegsLost,
  input wire logic clkGateAll,
  input wire logic clkWdtOnly,
  input wire logic periphReset,
  input wire logic portsHold,
  input wire logic portsHighZ,
  input wire logic wakeIrq,
  input wire logic wakeTransfer,
  input wire logic wakeNmi,
  input wire logic [5:0] modeOut
);
  // ==========================================================================
  // Helpers
  // Pins count as high only once the synchronisers have flushed.
  logic [2:0] pinHist;
  logic pinsHi;
  logic irqOk;
  always_ff @(posedge core_clk)
  begin
    pinHist <= {pinHist[1:0], reset_pin_n & standby_pin_n};
  end
  assign pinsHi = &pinHist & reset_pin_n & standby_pin_n;
  assign irqOk = irqPending & irqEnabled & (irqLevel > statusMaskLevel);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wake;
    (wakeIrq | wakeTransfer) && modeOut == PDMC_RUN ##1 !(wakeIrq | wakeTransfer);
  endsequence
  sequence s_nmiDone;
    wakeNmi && modeOut == PDMC_RUN && !clkWdtOnly;
  endsequence
  // ==========================================================================
  // Properties
  AST_SLEEP_ENTRY: assert property (modeOut == PDMC_RUN && sleepExec && pinsHi |=>
    modeOut == PDMC_SLEEP || modeOut == PDMC_SOFT_STANDBY_PIN_N) else $error("sleep entry wrong");
  AST_SLEEP_OUTS: assert property (modeOut == PDMC_SLEEP |-> cpuHalt && !clkGateAll
    && portsHold && !periphReset && !cpuRegsLost) else $error("sleep outputs wrong");
  AST_SOFT_OUTS: assert property (modeOut == PDMC_SOFT_STANDBY_PIN_N |-> cpuHalt && clkGateAll
    && periphReset && portsHold && !cpuRegsLost) else $error("soft standby outputs wrong");
  AST_HARD_OUTS: assert property (modeOut == PDMC_HARD_STANDBY_PIN_N |-> cpuHalt && cpuRegsLost
    && clkGateAll && portsHighZ) else $error("hard standby outputs wrong");
  AST_NO_WAKE: assert property (modeOut == PDMC_SLEEP && pinsHi && !irqOk |=>
    modeOut == PDMC_SLEEP) else $error("sleep left without wake");
  AST_IRQ_WAKE: assert property (modeOut == PDMC_SLEEP && pinsHi && irqOk |=> s_wake)
    else $error("interrupt wake wrong");
  AST_STANDBY_PIN_N_PIN: assert property (!standby_pin_n |-> ##[1:4] modeOut == PDMC_HARD_STANDBY_PIN_N)
    else $error("hard standby not entered");
  AST_RST_PIN: assert property ($fell(reset_pin_n) && standby_pin_n &&
    modeOut inside {PDMC_SLEEP, PDMC_SOFT_STANDBY_PIN_N} |-> ##[1:4] modeOut == PDMC_RESET)
    else $error("reset not entered");
  AST_HARD_EXIT: assert property (modeOut == PDMC_HARD_STANDBY_PIN_N |=>
    modeOut inside {PDMC_HARD_STANDBY_PIN_N, PDMC_RESET}) else $error("hard standby exit wrong");
  AST_NMI_SETTLE: assert property (modeOut == PDMC_SOFT_STANDBY_PIN_N && nmiEvent && pinsHi |=>
    clkWdtOnly && !wakeNmi ##[1:40] s_nmiDone) else $error("settle exit wrong");
  AST_RDATA: assert property (busRd && busAddr == STANDBY_CONTROL_ADDR |=>
    busRdata[6:0] == RESERVED_ONES) else $error("reserved bits wrong");
endmodule
bind power_down_mode_control pdmc_assertions chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .busAddr(busAddr), .busRd(busRd), .busRdata(busRdata), .sleepExec(sleepExec),
  .irqPending(irqPending), .irqEnabled(irqEnabled), .irqLevel(irqLevel),
  .statusMaskLevel(statusMaskLevel), .nmiEvent(nmiEvent), .reset_pin_n(reset_pin_n),
  .standby_pin_n(standby_pin_n), .cpuHalt(cpuHalt), .cpuRegsLost(cpuRegsLost),
  .clkGateAll(clkGateAll), .clkWdtOnly(clkWdtOnly), .periphReset(periphReset),
  .portsHold(portsHold), .portsHighZ(portsHighZ), .wakeIrq(wakeIrq),
  .wakeTransfer(wakeTransfer), .wakeNmi(wakeNmi), .modeOut(modeOut));

// file: bench/power_down_mode_control_bench.sv
// Self-checking bench for the power-down mode controller.
`timescale 1ns/100ps
module power_down_mode_control_bench
  import pdmc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] busAddr = 16'h0000;
  logic [7:0] busWdata = 8'h00;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic sleepExec = 1'b0;
  logic irqPending = 1'b0;
  logic irqEnabled = 1'b0;
  logic [2:0] irqLevel = 3'h0;
  logic [2:0] statusMaskLevel = 3'h3;
  logic irqIsTransfer = 1'b0;
  logic nmiEvent = 1'b0;
  logic watchdogTimerEnable = 1'b0;
  logic [19:0] watchdogSettleCycles = 20'h0_0005;
  logic stbyReq = 1'b0;
  logic rstReq = 1'b0;
  logic reset_pin_n, standby_pin_n, cpuHalt, cpuRegsLost, clkGateAll, clkWdtOnly;
  logic periphReset, portsHold, portsHighZ, chipReset, wakeIrq, wakeTransfer, wakeNmi;
  logic [7:0] busRdata;
  logic [5:0] modeOut;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  power_down_mode_control #(.SETTLE_W(20)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
    .busRdata(busRdata), .sleepExec(sleepExec), .irqPending(irqPending),
    .irqEnabled(irqEnabled), .irqLevel(irqLevel), .statusMaskLevel(statusMaskLevel),
    .irqIsTransfer(irqIsTransfer), .nmiEvent(nmiEvent),
    .watchdogTimerEnable(watchdogTimerEnable), .watchdogSettleCycles(watchdogSettleCycles),
    .reset_pin_n(reset_pin_n), .standby_pin_n(standby_pin_n), .cpuHalt(cpuHalt),
    .cpuRegsLost(cpuRegsLost), .clkGateAll(clkGateAll), .clkWdtOnly(clkWdtOnly),
    .periphReset(periphReset), .portsHold(portsHold), .portsHighZ(portsHighZ),
    .chipReset(chipReset), .wakeIrq(wakeIrq), .wakeTransfer(wakeTransfer),
    .wakeNmi(wakeNmi), .modeOut(modeOut));
  pdmc_far_side far_u (.core_clk(core_clk), .stbyReq(stbyReq), .rstReq(rstReq),
    .reset_pin_n(reset_pin_n), .standby_pin_n(standby_pin_n));
  initial forever #5 core_clk = ~core_clk;
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
      errors++;
    if (got !== exp)
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge core_clk);
    busWr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge core_clk);
    busRd <= 1'b0;
    #1 check(busRdata, exp);
  endtask
  // A selector stands in for a reference argument, which may not take a non-blocking write.
  task automatic pulse(input bit nmi);
    @(posedge core_clk);
    if (nmi)
      nmiEvent <= 1'b1;
    else
      sleepExec <= 1'b1;
    @(posedge core_clk);
    nmiEvent <= 1'b0;
    sleepExec <= 1'b0;
    #1;
  endtask
  task automatic waitMode(input pdmc_mode_e m);
    int k;
    k = 0;
    while (modeOut !== m && k < 50)
    begin
      @(posedge core_clk);
      #1 k++;
    end
    check({2'b00, modeOut}, {2'b00, m});
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rd(STANDBY_CONTROL_ADDR, 8'h7F);
    wr(STANDBY_CONTROL_ADDR, 8'h00);
    rd(STANDBY_CONTROL_ADDR, 8'h7F);
    watchdogTimerEnable <= 1'b1;
    wr(STANDBY_CONTROL_ADDR, 8'h80);
    rd(STANDBY_CONTROL_ADDR, 8'h7F);
    watchdogTimerEnable <= 1'b0;
    wr(STANDBY_CONTROL_ADDR, 8'h80);
    rd(STANDBY_CONTROL_ADDR, 8'hFF);
    rd(MODE_STATUS_ADDR, 8'h01);
    rd(16'h0000, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_soft;
    int k;
    pulse(1'b0);
    check({2'b00, modeOut}, {2'b00, PDMC_SOFT_STANDBY_PIN_N});
    check({cpuHalt, clkGateAll, periphReset, portsHold, cpuRegsLost}, 8'h1E);
    pulse(1'b1);
    check({7'h00, clkWdtOnly}, 8'h01);
    for (k = 1; k < 50 && modeOut !== PDMC_RUN; k++)
      @(posedge core_clk) #1;
    check(8'(k >= 5 && k <= 7), 8'h01);
    check({7'h00, wakeNmi}, 8'h01);
    rd(STANDBY_CONTROL_ADDR, 8'h7F);
    $display("t_soft done");
  endtask
  task automatic t_sleep;
    for (int t = 0; t < 2; t++)
    begin
      irqIsTransfer <= 1'(t);
      pulse(1'b0);
      check({2'b00, modeOut}, {2'b00, PDMC_SLEEP});
      check({cpuHalt, clkGateAll, periphReset, portsHold, cpuRegsLost}, 8'h12);
      irqPending <= 1'b1;
      irqEnabled <= 1'b1;
      irqLevel <= 3'h3;
      repeat (4) @(posedge core_clk);
      irqLevel <= 3'h5;
      irqEnabled <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 check({2'b00, modeOut}, {2'b00, PDMC_SLEEP});
      irqEnabled <= 1'b1;
      @(posedge core_clk);
      #1 check({6'h00, wakeTransfer, wakeIrq}, 8'(1 << t));
      irqPending <= 1'b0;
      waitMode(PDMC_RUN);
    end
    $display("t_sleep done");
  endtask
  task automatic t_pins;
    pulse(1'b0);
    rstReq <= 1'b1;
    waitMode(PDMC_RESET);
    check({5'h00, cpuHalt, clkGateAll, chipReset}, 8'h05);
    rstReq <= 1'b0;
    waitMode(PDMC_RUN);
    wr(STANDBY_CONTROL_ADDR, 8'h80);
    pulse(1'b0);
    rstReq <= 1'b1;
    waitMode(PDMC_RESET);
    check({5'h00, cpuHalt, clkGateAll, chipReset}, 8'h05);
    rstReq <= 1'b0;
    waitMode(PDMC_RUN);
    check({7'h00, chipReset}, 8'h00);
    rd(STANDBY_CONTROL_ADDR, 8'h7F);
    pulse(1'b0);
    stbyReq <= 1'b1;
    waitMode(PDMC_HARD_STANDBY_PIN_N);
    check({cpuHalt, cpuRegsLost, clkGateAll, portsHighZ}, 8'h0F);
    stbyReq <= 1'b0;
    waitMode(PDMC_RESET);
    waitMode(PDMC_RUN);
    wr(STANDBY_CONTROL_ADDR, 8'h80);
    stbyReq <= 1'b1;
    waitMode(PDMC_HARD_STANDBY_PIN_N);
    stbyReq <= 1'b0;
    waitMode(PDMC_RUN);
    rd(STANDBY_CONTROL_ADDR, 8'h7F);
    $display("t_pins done");
  endtask
  // ==========================================================================
  // Run control
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    waitMode(PDMC_RUN);
    t_regs();
    t_soft();
    t_sleep();
    t_pins();
    test_done();
  end
endmodule
